// File: shared/eop_pkg.sv
// constants and types for the energy pulse output control block
// assumes a 25 MHz metering clock and a 32-bit classic wishbone bus
package eop_pkg;
  localparam int ADR_W = 16;
  localparam int DAT_W = 32;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PH_PRI = 14'h287b;
  localparam logic [13:0] IDX_PH_SEC = 14'h287c;
  localparam logic [13:0] IDX_PM = 14'h287d;
  localparam logic [13:0] IDX_CF = 14'h287e;
  localparam logic [13:0] IDX_ST = 14'h287f;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int PH_TGT = 7;
  localparam int PM_CRP_SEC = 7;
  localparam int PM_CRP_PRI = 6;
  localparam int PM_CF_SEC = 5;
  localparam int PM_CF_PRI = 4;
  localparam int PM_ACC = 3;
  localparam int PM_SWAP = 2;
  localparam int CF_Q_SEC = 6;
  localparam int CF_Q_PRI = 4;
  localparam int CF_SEL_SEC = 2;
  localparam int CF_SEL_PRI = 0;
  localparam int ST_CRP_PRI = 7;
  localparam int ST_CRP_SEC = 6;
  localparam int ST_WD = 4;
  localparam int ST_LOW_SEC = 2;
  localparam int ST_LOW_PRI = 0;
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int PW_MS_0 = 80;
  localparam int PW_MS_1 = 40;
  localparam int PW_MS_2 = 20;
  localparam int PW_MS_3 = 10;
  localparam logic [5:0] NEED_X1 = 6'h10;
  localparam logic [5:0] NEED_X4 = 6'h04;
  localparam logic [5:0] NEED_X8 = 6'h02;
  localparam logic [5:0] NEED_X16 = 6'h01;
  localparam logic [1:0] ESEL_POS = 2'h1;
  localparam logic [1:0] ESEL_NEG = 2'h2;
  localparam logic [1:0] PSRC_RMS = 2'h1;
  localparam logic [1:0] PSRC_CONST = 2'h2;
  typedef enum logic [1:0] {SRC_POWER, SRC_RMS, SRC_CONST} eop_src_type;
  typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_GAP} eop_pg_state_type;
endpackage

// File: shared/eop_pulse_if.sv
// configuration and events between the control top and one pulse generator
// assumes a single clock domain
`timescale 1ns/1ps
interface eop_pulse_if;
  logic enable;
  logic [1:0] rate;
  logic [1:0] esel;
  logic [1:0] width;
  logic pos_ev;
  logic neg_ev;
  logic pulse;
  logic busy;
  modport gen (input enable, rate, esel, width, pos_ev, neg_ev, output pulse, busy);
  modport ctl (output enable, rate, esel, width, pos_ev, neg_ev, input pulse, busy);
endinterface

// File: shared/eop_reg_if.sv
// decoded register access between the bus slave and the register file
// assumes a single clock domain
`timescale 1ns/1ps
interface eop_reg_if;
  logic wr;
  logic hit;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr, hit, idx, wdata, input rdata);
  modport regs (input wr, hit, idx, wdata, output rdata);
endinterface

// File: rtl/eop_wb_slave.sv
// classic wishbone slave for the byte registers of the pulse control block
// assumes a master that holds its request until ack and then drops it
`timescale 1ns/1ps
module eop_wb_slave (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [eop_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [eop_pkg::DAT_W-1:0] wb_dat_i,
  output logic [eop_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  eop_reg_if.slave r
);
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  always_comb begin
    r.hit = 1'b1;
    r.idx = 3'h0;
    unique case (wb_adr_i[eop_pkg::ADR_W-1:2])
      eop_pkg::IDX_PH_PRI: r.idx = 3'h0;
      eop_pkg::IDX_PH_SEC: r.idx = 3'h1;
      eop_pkg::IDX_PM: r.idx = 3'h2;
      eop_pkg::IDX_CF: r.idx = 3'h3;
      eop_pkg::IDX_ST: r.idx = 3'h4;
      default: r.hit = 1'b0;
    endcase
  end
  // write lands on the edge at which the master samples ack
  assign r.wr = req && wb_we_i && wb_ack_o && wb_sel_i[0] && r.hit;
  assign r.wdata = wb_dat_i[7:0];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end
  // unmapped reads answer zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_ack_o && !wb_we_i && r.hit) begin
      wb_dat_o <= {24'h0, r.rdata};
    end else begin
      wb_dat_o <= 32'h0;
    end
  end
endmodule

// File: rtl/eop_pulse_gen.sv
// one energy-to-pulse converter: rate scaled counting and width timing
// assumes fine threshold events as one-cycle pulses on the same clock
`timescale 1ns/1ps
module eop_pulse_gen #(
  parameter int CYC_PER_MS = eop_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  eop_pulse_if.gen p
);
  if (CYC_PER_MS < 1 || CYC_PER_MS > 1000000) begin : g_chk
    $error("cycles per ms out of range");
  end
  eop_pkg::eop_pg_state_type state;
  logic [5:0] acc;
  logic [1:0] add;
  logic [5:0] need;
  logic [6:0] sum;
  logic [31:0] wid;
  logic [31:0] tmr;
  logic [31:0] hi_cnt;
  logic [31:0] wid_lat;
  logic fire;
  logic pend;
  always_comb begin
    unique case (p.esel)
      eop_pkg::ESEL_POS: add = {1'b0, p.pos_ev};
      eop_pkg::ESEL_NEG: add = {1'b0, p.neg_ev};
      default: add = {1'b0, p.pos_ev} + {1'b0, p.neg_ev};
    endcase
    unique case (p.rate)
      2'h0: need = eop_pkg::NEED_X1;
      2'h1: need = eop_pkg::NEED_X4;
      2'h2: need = eop_pkg::NEED_X8;
      default: need = eop_pkg::NEED_X16;
    endcase
    unique case (p.width)
      2'h0: wid = 32'(eop_pkg::PW_MS_0 * CYC_PER_MS);
      2'h1: wid = 32'(eop_pkg::PW_MS_1 * CYC_PER_MS);
      2'h2: wid = 32'(eop_pkg::PW_MS_2 * CYC_PER_MS);
      default: wid = 32'(eop_pkg::PW_MS_3 * CYC_PER_MS);
    endcase
  end
  assign sum = {1'b0, acc} + {5'h0, add};
  assign fire = p.enable && (sum >= {1'b0, need});
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc <= 6'h0;
    end else if (fire) begin
      acc <= (sum - {1'b0, need} > 7'h3f) ? 6'h3f : 6'(sum - {1'b0, need});
    end else if (p.enable) begin
      acc <= sum[5:0];
    end
  end
  // a crossing during a pulse or its gap waits in pend; disabling the path drops it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= eop_pkg::PG_IDLE;
      tmr <= 32'h0;
      pend <= 1'b0;
      p.pulse <= 1'b0;
      wid_lat <= 32'h0;
    end else begin
      unique case (state)
        eop_pkg::PG_IDLE: begin
          pend <= 1'b0;
          if (fire || (pend && p.enable)) begin
            state <= eop_pkg::PG_HIGH;
            p.pulse <= 1'b1;
            tmr <= wid - 32'h1;
            wid_lat <= wid;
          end
        end
        eop_pkg::PG_HIGH: begin
          pend <= (pend && p.enable) || fire;
          if (tmr == 32'h0) begin
            state <= eop_pkg::PG_GAP;
            p.pulse <= 1'b0;
            tmr <= wid_lat - 32'h1;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
        eop_pkg::PG_GAP: begin
          pend <= (pend && p.enable) || fire;
          if (tmr == 32'h0) begin
            state <= eop_pkg::PG_IDLE;
          end else begin
            tmr <= tmr - 32'h1;
          end
        end
      endcase
    end
  end
  assign p.busy = (state != eop_pkg::PG_IDLE);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 32'h0;
    end else begin
      hi_cnt <= p.pulse ? hi_cnt + 32'h1 : 32'h0;
    end
  end
  a_pulse_width: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(p.pulse) |-> hi_cnt == wid_lat) else $error("pulse width wrong");
  a_pulse_cause: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(p.pulse) |-> $past(fire || pend)) else $error("pulse without crossing");
endmodule

// File: rtl/eop_ctrl_top.sv
// register file, path gating, pin mapping and creep status of the pulse block
// assumes energy crossing events and creep detects come from logic on mclk
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module eop_ctrl_top #(
  parameter int CYC_PER_MS = eop_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [eop_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [eop_pkg::DAT_W-1:0] wb_dat_i,
  output logic [eop_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic primary_pos_event,
  input wire logic primary_neg_event,
  input wire logic secondary_pos_event,
  input wire logic secondary_neg_event,
  input wire logic primary_creep_detect,
  input wire logic secondary_creep_detect,
  output logic pulse_pin_a,
  output logic pulse_pin_b,
  output logic [7:0] primary_delay,
  output logic [7:0] secondary_delay,
  output logic primary_delay_target,
  output logic secondary_delay_target,
  output logic accumulate_enable,
  output eop_pkg::eop_src_type accumulation_source_select,
  output logic primary_noload_enable,
  output logic secondary_noload_enable
);
  if (CYC_PER_MS < 1) begin : g_chk
    $error("cycles per ms must be positive");
  end
  eop_reg_if r ();
  eop_pulse_if p_pri ();
  eop_pulse_if p_sec ();
  logic [7:0] ph_pri;
  logic [7:0] ph_sec;
  logic [7:0] pm;
  logic [7:0] cf;
  logic [5:0] st;
  logic primary_creep_flag;
  logic secondary_creep_flag;

  eop_wb_slave u_bus (
    .mclk(mclk),
    .rstn(rstn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .r(r.slave)
  );

  // register writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ph_pri <= eop_pkg::REG_RST;
    end else if (r.wr && r.idx == 3'h0) begin
      ph_pri <= r.wdata & 8'hbf;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ph_sec <= eop_pkg::REG_RST;
    end else if (r.wr && r.idx == 3'h1) begin
      ph_sec <= r.wdata & 8'hbf;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pm <= eop_pkg::REG_RST;
    end else if (r.wr && r.idx == 3'h2) begin
      pm <= r.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cf <= eop_pkg::REG_RST;
    end else if (r.wr && r.idx == 3'h3) begin
      cf <= r.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= eop_pkg::REG_RST[5:0];
    end else if (r.wr && r.idx == 3'h4) begin
      st <= r.wdata[5:0];
    end
  end

  // register reads; unused bit 6 of the delay controls reads zero
  always_comb begin
    unique case (r.idx)
      3'h0: r.rdata = ph_pri;
      3'h1: r.rdata = ph_sec;
      3'h2: r.rdata = pm;
      3'h3: r.rdata = cf;
      3'h4: r.rdata = {primary_creep_flag, secondary_creep_flag, st};
      default: r.rdata = 8'h00;
    endcase
  end

  // 8-bit delays, 0.0055 degree per step at the 3.2768 MHz sampling rate
  assign primary_delay = {ph_pri[5:0], st[eop_pkg::ST_LOW_PRI+:2]};
  assign secondary_delay = {ph_sec[5:0], st[eop_pkg::ST_LOW_SEC+:2]};
  assign primary_delay_target = ph_pri[eop_pkg::PH_TGT];
  assign secondary_delay_target = ph_sec[eop_pkg::PH_TGT];
  assign accumulate_enable = pm[eop_pkg::PM_ACC];
  assign primary_noload_enable = pm[eop_pkg::PM_CRP_PRI];
  assign secondary_noload_enable = pm[eop_pkg::PM_CRP_SEC];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accumulation_source_select <= eop_pkg::SRC_POWER;
    end else begin
      unique case (pm[1:0])
        eop_pkg::PSRC_RMS: accumulation_source_select <= eop_pkg::SRC_RMS;
        eop_pkg::PSRC_CONST: accumulation_source_select <= eop_pkg::SRC_CONST;
        default: accumulation_source_select <= eop_pkg::SRC_POWER;
      endcase
    end
  end

  // creep flags follow detection only while detection is enabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      primary_creep_flag <= 1'b0;
    end else begin
      primary_creep_flag <= primary_noload_enable && primary_creep_detect;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      secondary_creep_flag <= 1'b0;
    end else begin
      secondary_creep_flag <= secondary_noload_enable && secondary_creep_detect;
    end
  end

  // a creeping path stops converting energy
  assign p_pri.enable = accumulate_enable && pm[eop_pkg::PM_CF_PRI]
    && !primary_creep_flag;
  assign p_sec.enable = accumulate_enable && pm[eop_pkg::PM_CF_SEC]
    && !secondary_creep_flag;
  assign p_pri.rate = cf[eop_pkg::CF_Q_PRI+:2];
  assign p_sec.rate = cf[eop_pkg::CF_Q_SEC+:2];
  assign p_pri.esel = cf[eop_pkg::CF_SEL_PRI+:2];
  assign p_sec.esel = cf[eop_pkg::CF_SEL_SEC+:2];
  assign p_pri.width = st[eop_pkg::ST_WD+:2];
  assign p_sec.width = st[eop_pkg::ST_WD+:2];
  assign p_pri.pos_ev = primary_pos_event;
  assign p_pri.neg_ev = primary_neg_event;
  assign p_sec.pos_ev = secondary_pos_event;
  assign p_sec.neg_ev = secondary_neg_event;

  eop_pulse_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_pg_pri (
    .mclk(mclk),
    .rstn(rstn),
    .p(p_pri.gen)
  );

  eop_pulse_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_pg_sec (
    .mclk(mclk),
    .rstn(rstn),
    .p(p_sec.gen)
  );

  // pin mapping; clearing PM_CF_PRI or PM_CF_SEC cuts that path's registered pin off one cycle later, even mid-pulse
  logic pri_out;
  logic sec_out;
  assign pri_out = p_pri.pulse && pm[eop_pkg::PM_CF_PRI];
  assign sec_out = p_sec.pulse && pm[eop_pkg::PM_CF_SEC];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_pin_a <= 1'b0;
    end else begin
      pulse_pin_a <= pm[eop_pkg::PM_SWAP] ? sec_out : pri_out;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_pin_b <= 1'b0;
    end else begin
      pulse_pin_b <= pm[eop_pkg::PM_SWAP] ? pri_out : sec_out;
    end
  end

  a_sec_delay_up: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h1) |=> secondary_delay[7:2] == $past(r.wdata[5:0]))
    else $error("secondary delay upper bits not taken");
  a_sec_delay_low: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h4) |=> secondary_delay[1:0] == $past(r.wdata[3:2]))
    else $error("secondary delay lower bits not taken");
  a_pri_delay_low: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h4) |=> primary_delay[1:0] == $past(r.wdata[1:0])
    && primary_delay[7:2] == $past(ph_pri[5:0]))
    else $error("primary delay not formed");
  a_noload_off: assert property (@(posedge mclk) disable iff (!rstn)
    !primary_noload_enable |=> !primary_creep_flag)
    else $error("creep flag while detection off");
  a_creep_report: assert property (@(posedge mclk) disable iff (!rstn)
    (primary_noload_enable && primary_creep_detect && !r.wr) |=> r.idx != 3'h4
    || r.rdata[eop_pkg::ST_CRP_PRI])
    else $error("primary creep not reported");
  a_creep_sec: assert property (@(posedge mclk) disable iff (!rstn)
    secondary_creep_flag |-> $past(secondary_noload_enable && secondary_creep_detect))
    else $error("secondary creep flag without cause");
  a_pulse_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (!pm[eop_pkg::PM_CF_PRI] && !pm[eop_pkg::PM_CF_SEC]) |=> !pulse_pin_a && !pulse_pin_b)
    else $error("pulse out while disabled");
  a_acc_gate: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(p_pri.pulse) |-> $past(accumulate_enable))
    else $error("pulse started with accumulation off");
  a_pin_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (pm[eop_pkg::PM_SWAP] && pri_out) |=> pulse_pin_b)
    else $error("swapped primary not on pin b");
  a_pin_direct: assert property (@(posedge mclk) disable iff (!rstn)
    (!pm[eop_pkg::PM_SWAP] && pri_out) |=> pulse_pin_a)
    else $error("primary not on pin a");
  a_src_const: assert property (@(posedge mclk) disable iff (!rstn)
    (pm[1:0] == eop_pkg::PSRC_CONST) |=> accumulation_source_select == eop_pkg::SRC_CONST
    || $past(r.wr))
    else $error("constant source not selected");
  a_rate_x16: assert property (@(posedge mclk) disable iff (!rstn)
    (p_sec.enable && p_sec.rate == 2'h3 && p_sec.esel == eop_pkg::ESEL_POS
    && secondary_pos_event && !p_sec.busy) |=> p_sec.pulse)
    else $error("x16 rate missed a pulse");
  a_neg_only: assert property (@(posedge mclk) disable iff (!rstn)
    (p_pri.rate == 2'h3 && p_pri.esel == eop_pkg::ESEL_NEG && !p_pri.busy
    && !primary_neg_event && !primary_pos_event && !u_pg_pri.pend
    && u_pg_pri.acc == 6'h0) |=> !p_pri.pulse)
    else $error("pulse without selected energy");
  a_target_pri: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h0) |=> primary_delay_target == $past(r.wdata[7]))
    else $error("delay target not taken");
  a_reset_zero: assert property (@(posedge mclk)
    $rose(rstn) |-> pm == 8'h00 && cf == 8'h00 && st == 6'h00 && !pulse_pin_a)
    else $error("control not zero after reset");

  // expected pulse width in cycles, reckoned apart from the generators
  logic [31:0] wid_exp;
  always_comb begin
    unique case (st[eop_pkg::ST_WD+:2])
      2'h0: wid_exp = 32'(eop_pkg::PW_MS_0 * CYC_PER_MS);
      2'h1: wid_exp = 32'(eop_pkg::PW_MS_1 * CYC_PER_MS);
      2'h2: wid_exp = 32'(eop_pkg::PW_MS_2 * CYC_PER_MS);
      default: wid_exp = 32'(eop_pkg::PW_MS_3 * CYC_PER_MS);
    endcase
  end

  a_ack_single: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  a_ack_cause: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");

  a_regs_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !r.wr |=> $stable(ph_pri) && $stable(ph_sec) && $stable(pm) && $stable(cf) && $stable(st))
    else $error("register changed without write");

  a_pri_delay_up: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h0) |=> primary_delay[7:2] == $past(r.wdata[5:0]))
    else $error("primary delay upper bits not taken");

  a_sec_target: assert property (@(posedge mclk) disable iff (!rstn)
    (r.wr && r.idx == 3'h1) |=> secondary_delay_target == $past(r.wdata[7]))
    else $error("secondary delay target not taken");

  a_noload_sec_off: assert property (@(posedge mclk) disable iff (!rstn)
    !secondary_noload_enable |=> !secondary_creep_flag)
    else $error("secondary creep flag while detection off");

  a_src_rms: assert property (@(posedge mclk) disable iff (!rstn)
    (pm[1:0] == eop_pkg::PSRC_RMS) |=> accumulation_source_select == eop_pkg::SRC_RMS)
    else $error("rms source not selected");

  a_src_power: assert property (@(posedge mclk) disable iff (!rstn)
    (pm[1:0] == 2'h0 || pm[1:0] == 2'h3) |=> accumulation_source_select == eop_pkg::SRC_POWER)
    else $error("power source not selected");

  a_sec_pin_direct: assert property (@(posedge mclk) disable iff (!rstn)
    (!pm[eop_pkg::PM_SWAP] && sec_out) |=> pulse_pin_b) else $error("secondary not on pin b");

  a_sec_pin_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (pm[eop_pkg::PM_SWAP] && sec_out) |=> pulse_pin_a) else $error("secondary not on pin a");

  a_width_pri: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(p_pri.pulse) |-> u_pg_pri.wid_lat == $past(wid_exp))
    else $error("primary pulse width not latched");

  a_width_sec: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(p_sec.pulse) |-> u_pg_sec.wid_lat == $past(wid_exp))
    else $error("secondary pulse width not latched");

  a_rate_x1: assert property (@(posedge mclk) disable iff (!rstn)
    (p_pri.rate == 2'h0 && u_pg_pri.acc <= 6'hd && !u_pg_pri.pend && !p_pri.busy)
    |=> !p_pri.pulse) else $error("x1 rate pulsed early");

  a_rate_x4: assert property (@(posedge mclk) disable iff (!rstn)
    (p_sec.rate == 2'h1 && u_pg_sec.acc <= 6'h1 && !u_pg_sec.pend && !p_sec.busy)
    |=> !p_sec.pulse) else $error("x4 rate pulsed early");

  c_pin_a_pulse: cover property (@(posedge mclk) disable iff (!rstn) $rose(pulse_pin_a));
  c_swapped: cover property (@(posedge mclk) disable iff (!rstn)
    pm[eop_pkg::PM_SWAP] && $rose(pulse_pin_b));
  c_creep: cover property (@(posedge mclk) disable iff (!rstn) $rose(secondary_creep_flag));
  c_read_ack: cover property (@(posedge mclk) disable iff (!rstn) wb_ack_o && !wb_we_i);
  c_rate_x1: cover property (@(posedge mclk) disable iff (!rstn) $rose(p_pri.pulse) && p_pri.rate == 2'h0);
endmodule

// File: tb/eop_pulse_meter.sv
// meter test equipment model: counts finished pulses on one pin, keeps last width
// assumes the pin is driven synchronously to mclk
`timescale 1ns/1ps
module eop_pulse_meter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin,
  output int count,
  output int width
);
  int run;
  // a pulse is tallied when it ends, so its width is known
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= 0;
      width <= 0;
      run <= 0;
    end else if (pin) begin
      run <= run + 1;
    end else if (run != 0) begin
      count <= count + 1;
      width <= run;
      run <= 0;
    end
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the pulse control block over classic wishbone
// assumes one 25 MHz clock and a small cycles-per-ms parameter
`timescale 1ns/1ps
module tb;
  localparam int CPM = 2;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  // {sec_neg, sec_pos, pri_neg, pri_pos}
  logic [3:0] ev = 4'h0;
  // {sec, pri}
  logic [1:0] crp = 2'h0;
  logic pin_a, pin_b, pt, st, acc, pne, sne;
  logic [7:0] pd, sd;
  eop_pkg::eop_src_type src;
  logic [31:0] q;
  int n_mismatch = 0;
  int n_compared = 0;
  int cnt_a, cnt_b, wid_a, wid_b, ca, cb, need;
  int pw[4] = '{80, 40, 20, 10};

  always #20 mclk = ~mclk;

  eop_ctrl_top #(.CYC_PER_MS(CPM)) dut (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .primary_pos_event(ev[0]), .primary_neg_event(ev[1]),
    .secondary_pos_event(ev[2]), .secondary_neg_event(ev[3]),
    .primary_creep_detect(crp[0]), .secondary_creep_detect(crp[1]),
    .pulse_pin_a(pin_a), .pulse_pin_b(pin_b), .primary_delay(pd), .secondary_delay(sd),
    .primary_delay_target(pt), .secondary_delay_target(st), .accumulate_enable(acc),
    .accumulation_source_select(src), .primary_noload_enable(pne),
    .secondary_noload_enable(sne)
  );
  eop_pulse_meter meter_a (.mclk(mclk), .rstn(rstn), .pin(pin_a), .count(cnt_a), .width(wid_a));
  eop_pulse_meter meter_b (.mclk(mclk), .rstn(rstn), .pin(pin_b), .count(cnt_b), .width(wid_b));

  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [13:0] idx, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    chk(q, {24'h0, exp});
  endtask

  task automatic fire(input logic [3:0] m, input int n);
    repeat (n) begin
      ev <= m;
      @(posedge mclk);
      ev <= 4'h0;
      @(posedge mclk);
    end
  endtask

  // longest pulse plus its gap plus pipeline
  task automatic settle;
    repeat (330) @(posedge mclk);
  endtask

  task automatic pulses(input int da, input int db);
    chk(cnt_a - ca, da);
    chk(cnt_b - cb, db);
    ca = cnt_a;
    cb = cnt_b;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    ca = 0;
    cb = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd_chk(eop_pkg::IDX_PH_PRI + 14'(i), 8'h00);
    chk({pd, sd, pt, st, acc, pne, sne, pin_a, pin_b}, 32'h0);
    chk(32'(src), 32'(eop_pkg::SRC_POWER));
    wr(14'h0001, 8'hff);
    rd_chk(14'h0001, 8'h00);
    wr(eop_pkg::IDX_PH_PRI, 8'hff);
    wr(eop_pkg::IDX_PH_SEC, 8'h85);
    wr(eop_pkg::IDX_ST, 8'hf6);
    rd_chk(eop_pkg::IDX_PH_PRI, 8'hbf);
    rd_chk(eop_pkg::IDX_ST, 8'h36);
    chk(pd, 8'hfe);
    chk(sd, 8'h15);
    chk({pt, st}, 2'b11);
    rd_chk(eop_pkg::IDX_PH_SEC, 8'h85);
    for (int s = 0; s < 4; s++) begin
      wr(eop_pkg::IDX_PM, 8'(s));
      @(posedge mclk);
      chk(32'(src), (s == 1) ? 32'h1 : (s == 2) ? 32'h2 : 32'h0);
    end
    // width codes, x16 rate, positive energy on the primary path only
    wr(eop_pkg::IDX_CF, 8'hf5);
    wr(eop_pkg::IDX_PM, 8'h38);
    for (int w = 0; w < 4; w++) begin
      wr(eop_pkg::IDX_ST, 8'(w << 4));
      fire(4'h1, 1);
      settle;
      pulses(1, 0);
      chk(wid_a, pw[w] * CPM);
    end
    for (int s = 0; s < 4; s++) begin
      wr(eop_pkg::IDX_CF, 8'hf0 | 8'(s << 2) | 8'(s));
      fire(4'h5, 1);
      settle;
      pulses(s != 2, s != 2);
      fire(4'ha, 1);
      settle;
      pulses(s != 1, s != 1);
    end
    for (int r = 0; r < 4; r++) begin
      need = (r == 0) ? 16 : (r == 1) ? 4 : (r == 2) ? 2 : 1;
      wr(eop_pkg::IDX_CF, {2'(r), 2'(r), 4'h5});
      fire(4'h5, need - 1);
      settle;
      pulses(0, 0);
      fire(4'h5, 1);
      settle;
      pulses(1, 1);
    end
    wr(eop_pkg::IDX_PM, 8'h3c);
    fire(4'h1, 1);
    settle;
    pulses(0, 1);
    fire(4'h4, 1);
    settle;
    pulses(1, 0);
    wr(eop_pkg::IDX_PM, 8'h28);
    fire(4'h5, 1);
    settle;
    pulses(0, 1);
    wr(eop_pkg::IDX_PM, 8'h30);
    chk(acc, 1'b0);
    fire(4'h5, 1);
    settle;
    pulses(0, 0);
    wr(eop_pkg::IDX_PM, 8'hf8);
    chk({pne, sne, acc}, 3'b111);
    crp <= 2'b01;
    repeat (2) @(posedge mclk);
    rd_chk(eop_pkg::IDX_ST, 8'hb0);
    fire(4'h5, 1);
    settle;
    pulses(0, 1);
    crp <= 2'b10;
    repeat (2) @(posedge mclk);
    rd_chk(eop_pkg::IDX_ST, 8'h70);
    wr(eop_pkg::IDX_PM, 8'h38);
    @(posedge mclk);
    rd_chk(eop_pkg::IDX_ST, 8'h30);
    // reset again in mid-run: the primary phase, mode and status registers must read back zero
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_chk(eop_pkg::IDX_PH_PRI, 8'h00);
    rd_chk(eop_pkg::IDX_PM, 8'h00);
    rd_chk(eop_pkg::IDX_ST, 8'h00);
    give_verdict;
  end
endmodule
